// File: led_driver.sv
// Network indicator LED driver: link/activity, run-state and error LEDs,
// with an AXI4-Lite register slave for status, interrupts and pin sharing.
// Assumes all inputs synchronous to clk; state machine and watchdogs live
// outside and only report levels here.
//
// How it works
// - Link LED on for idle link, flickers on activity, off without link.
// - Incoming port drives port-in LED, outgoing port drives port-out LED.
// - Run-state LED steadily on in the running state.
// - Mailbox-only state: run LED blinks 200 ms on, 200 ms off.
// - Inputs-only state: run LED single flash, 200 ms on, 1000 ms off.
// - Booting, firmware-load or download: run LED flickers 50/50 ms.
// - Startup state: run LED held off.
// - Host data port watchdog timeout: error LED steadily on.
// - Configuration error: error LED blinks 200 ms on, 200 ms off.
// - Booting error, or startup state with unsolicited flag 0x01: error LED flickers 50/50.
// - Unsolicited state change by application: error LED single flash.
// - Synchronization error shows as error LED single flash.
// - Application watchdog: double flash 200/200/200 then 1000 ms off.
// - Buffer channel watchdog counts as application watchdog.
// - Error LED shares I2C data pins; drive arbitrated with I2C.
`timescale 1ns/100ps
`include "led_defines.svh"

module led_driver
(
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst,
   // Network status
   input  wire led_pkg::port_type       port_in,
   input  wire led_pkg::port_type       port_out,
   input  wire led_pkg::slave_state_type slave_state,
   input  wire logic                    fw_download,
   input  wire logic [7:0]              app_layer_state_reg,
   input  wire led_pkg::err_type        err,
   // I2C data pin sharing
   input  wire logic                    i2c_sda_o,
   input  wire logic                    i2c_sda_oe,
   // LED and interrupt outputs
   output logic                         port_in_link_indicator,
   output logic                         port_out_link_indicator,
   output logic                         run_led,
   output logic                         err_sda_o,
   output logic                         err_sda_oe,
   output logic                         irq,
   // AXI4-Lite slave
   input  wire logic [`ADDR_W-1:0]      s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [`ADDR_W-1:0]      s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready
);

   // Level of a pattern at a given ms position; position wraps in the cycle
   function automatic logic pat_level(input led_pkg::pattern_type p,
                                      input logic [`PHASE_CNT_W-1:0] t);
      case (p)
         led_pkg::PAT_ON:      pat_level = 1'b1;
         led_pkg::PAT_BLINK:   pat_level = (t < `BLINK_MS);
         led_pkg::PAT_SINGLE:  pat_level = (t < `BLINK_MS);
         led_pkg::PAT_DOUBLE:  pat_level = (t < `BLINK_MS) ||
            (t >= 2 * `BLINK_MS && t < 3 * `BLINK_MS);
         led_pkg::PAT_FLICKER: pat_level = (t < `FLICKER_MS);
         default:              pat_level = 1'b0;
      endcase
   endfunction

   // Length of one pattern cycle in ms
   function automatic logic [`PHASE_CNT_W-1:0] pat_len(
      input led_pkg::pattern_type p);
      case (p)
         led_pkg::PAT_BLINK:   pat_len = `PHASE_CNT_W'(2 * `BLINK_MS);
         led_pkg::PAT_SINGLE:  pat_len = `PHASE_CNT_W'(`BLINK_MS +
                                                        `LONG_OFF_MS);
         led_pkg::PAT_DOUBLE:  pat_len = `PHASE_CNT_W'(3 * `BLINK_MS +
                                                        `LONG_OFF_MS);
         led_pkg::PAT_FLICKER: pat_len = `PHASE_CNT_W'(2 * `FLICKER_MS);
         default:              pat_len = `PHASE_CNT_W'(1);
      endcase
   endfunction

   // Next position in a pattern cycle
   function automatic logic [`PHASE_CNT_W-1:0] pat_next(
      input led_pkg::pattern_type p, input logic [`PHASE_CNT_W-1:0] t);
      pat_next = (t + `PHASE_CNT_W'(1) >= pat_len(p)) ?
                 `PHASE_CNT_W'(0) : t + `PHASE_CNT_W'(1);
   endfunction

   logic [`TICK_CNT_W-1:0]  tick_cnt_q;
   logic                    tick_q;
   logic [`PHASE_CNT_W-1:0] act_t_q;
   led_pkg::pattern_type    run_pat_d, run_pat_q;
   led_pkg::pattern_type    err_pat_d, err_pat_q;
   logic [`PHASE_CNT_W-1:0] run_t_q, err_t_q;
   logic                    unsol;
   logic                    i2c_own_q;
   logic [`IRQ_W-1:0]       irq_stat_q, irq_mask_q, irq_ev;
   logic [`IRQ_W-1:0]       cond_q;

   // One ms tick shared by every pattern; one divider keeps LEDs in step
   always_ff @(posedge clk)
   begin
      if (rst || tick_cnt_q == `TICK_CNT_W'(`TICK_CYCLES - 1))
         tick_cnt_q <= '0;
      else
         tick_cnt_q <= tick_cnt_q + `TICK_CNT_W'(1);
      tick_q <= !rst && tick_cnt_q == `TICK_CNT_W'(`TICK_CYCLES - 1);
   end

   // Activity flicker phase, free running for both ports
   always_ff @(posedge clk)
   begin
      if (rst)
         act_t_q <= '0;
      else if (tick_q)
         act_t_q <= pat_next(led_pkg::PAT_FLICKER, act_t_q);
   end

   // Link/activity LEDs, one per port
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         port_in_link_indicator  <= 1'b0;
         port_out_link_indicator <= 1'b0;
      end
      else
      begin
         port_in_link_indicator  <= port_in.link_ok && (!port_in.activity ||
            pat_level(led_pkg::PAT_FLICKER, act_t_q));
         port_out_link_indicator <= port_out.link_ok &&
            (!port_out.activity ||
             pat_level(led_pkg::PAT_FLICKER, act_t_q));
      end
   end

   // Run-state pattern selection
   always_comb
   begin
      if (fw_download)
      begin
         run_pat_d = led_pkg::PAT_FLICKER;
      end
      else
      begin
         case (slave_state)
            led_pkg::ST_RUNNING:      run_pat_d = led_pkg::PAT_ON;
            led_pkg::ST_MAILBOX_ONLY: run_pat_d = led_pkg::PAT_BLINK;
            led_pkg::ST_INPUTS_ONLY:  run_pat_d = led_pkg::PAT_SINGLE;
            led_pkg::ST_STARTUP:      run_pat_d = led_pkg::PAT_OFF;
            default:                  run_pat_d = led_pkg::PAT_FLICKER;
         endcase
      end
   end

   // Error pattern selection in order of severity
   assign unsol = app_layer_state_reg == `UNSOLICITED_VAL;
   always_comb
   begin
      if (err.host_wd)
         err_pat_d = led_pkg::PAT_ON;
      else if (err.boot_err ||
               (slave_state == led_pkg::ST_STARTUP && unsol))
         err_pat_d = led_pkg::PAT_FLICKER;
      else if (err.cfg_err)
         err_pat_d = led_pkg::PAT_BLINK;
      else if (err.app_wd || err.bufch_wd)
         err_pat_d = led_pkg::PAT_DOUBLE;
      else if (unsol || err.sync_err)
         err_pat_d = led_pkg::PAT_SINGLE;
      else
         err_pat_d = led_pkg::PAT_OFF;
   end

   // Pattern phase counters; a new pattern restarts at its on phase
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         run_pat_q <= led_pkg::PAT_OFF;
         err_pat_q <= led_pkg::PAT_OFF;
         run_t_q   <= '0;
         err_t_q   <= '0;
      end
      else
      begin
         run_pat_q <= run_pat_d;
         err_pat_q <= err_pat_d;
         if (run_pat_d != run_pat_q)
            run_t_q <= '0;
         else if (tick_q)
            run_t_q <= pat_next(run_pat_q, run_t_q);
         if (err_pat_d != err_pat_q)
            err_t_q <= '0;
         else if (tick_q)
            err_t_q <= pat_next(err_pat_q, err_t_q);
      end
   end

   // LED drive; I2C owns the shared pin only while software grants it
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         run_led    <= 1'b0;
         err_sda_o  <= 1'b0;
         err_sda_oe <= 1'b0;
      end
      else
      begin
         run_led <= pat_level(run_pat_q, run_t_q);
         if (i2c_own_q)
         begin
            err_sda_o  <= i2c_sda_o;
            err_sda_oe <= i2c_sda_oe;
         end
         else
         begin
            err_sda_o  <= pat_level(err_pat_q, err_t_q);
            err_sda_oe <= 1'b1;
         end
      end
   end

   // Rising edges of error conditions become interrupt events
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cond_q <= '0;
      end
      else
      begin
         cond_q <= irq_ev | cond_q & {err.sync_err, unsol,
            err.app_wd | err.bufch_wd, err.cfg_err, err.boot_err,
            err.host_wd};
      end
   end
   assign irq_ev = {err.sync_err, unsol, err.app_wd | err.bufch_wd,
                    err.cfg_err, err.boot_err, err.host_wd} & ~cond_q;

   // AXI4-Lite write path: address and data taken in either order
   logic                aw_hold_q, w_hold_q;
   logic [`ADDR_W-1:0]  aw_q;
   logic [31:0]         w_q;
   logic [3:0]          ws_q;
   logic                do_wr;
   assign do_wr = aw_hold_q && w_hold_q && !s_axi_bvalid;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         aw_hold_q     <= 1'b0;
         w_hold_q      <= 1'b0;
         aw_q          <= '0;
         w_q           <= '0;
         ws_q          <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awready && s_axi_awvalid)
         begin
            aw_hold_q <= 1'b1;
            aw_q      <= s_axi_awaddr;
         end
         if (s_axi_wready && s_axi_wvalid)
         begin
            w_hold_q <= 1'b1;
            w_q      <= s_axi_wdata;
            ws_q     <= s_axi_wstrb;
         end
         if (do_wr)
         begin
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_q == `REG_INT_STATUS ||
                             aw_q == `REG_INT_MASK ||
                             aw_q == `REG_CONTROL) ? `RESP_OKAY
                                                   : `RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Writable registers; a new event wins over a clear in the same cycle
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         irq_stat_q <= '0;
         irq_mask_q <= '0;
         i2c_own_q  <= 1'b0;
      end
      else
      begin
         irq_stat_q <= (irq_stat_q &
            ~((do_wr && aw_q == `REG_INT_STATUS && ws_q[0]) ?
              w_q[`IRQ_W-1:0] : '0)) | irq_ev;
         if (do_wr && aw_q == `REG_INT_MASK && ws_q[0])
            irq_mask_q <= w_q[`IRQ_W-1:0];
         if (do_wr && aw_q == `REG_CONTROL && ws_q[0])
            i2c_own_q <= w_q[`CTRL_I2C_OWN];
      end
   end

   // Interrupt output from a flop
   always_ff @(posedge clk)
   begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= |(irq_stat_q & irq_mask_q);
   end

   // AXI4-Lite read path
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= `RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arready && s_axi_arvalid)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            case (s_axi_araddr)
               `REG_STATUS:     s_axi_rdata <= {12'h000, 2'h0, run_pat_q,
                                   2'h0, err_pat_q, 1'b0, run_led,
                                   port_out_link_indicator,
                                   port_in_link_indicator};
               `REG_INT_STATUS: s_axi_rdata <= 32'(irq_stat_q);
               `REG_INT_MASK:   s_axi_rdata <= 32'(irq_mask_q);
               `REG_CONTROL:    s_axi_rdata <= 32'(i2c_own_q);
               default:
               begin
                  s_axi_rdata <= '0;
                  s_axi_rresp <= `RESP_SLVERR;
               end
            endcase
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule // led_driver

// File: led_defines.svh
// Timing and register constants for the network indicator LED driver.
// Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef LED_DEFINES_SVH
`define LED_DEFINES_SVH

`define CLK_FREQ_HZ        250000000
`define TICK_PERIOD_MS     1
`define TICK_CYCLES        (`CLK_FREQ_HZ / 1000 * `TICK_PERIOD_MS)
`define TICK_CNT_W         18
`define FLICKER_MS         50
`define BLINK_MS           200
`define LONG_OFF_MS        1000
`define PHASE_CNT_W        11
`define UNSOLICITED_VAL    8'h01

// Register offsets, byte addresses
`define REG_STATUS         4'h0
`define REG_INT_STATUS     4'h4
`define REG_INT_MASK       4'h8
`define REG_CONTROL        4'hC
`define ADDR_W             4

// Interrupt status bit positions
`define IRQ_HOST_WD        0
`define IRQ_BOOT_ERR       1
`define IRQ_CFG_ERR        2
`define IRQ_APP_WD         3
`define IRQ_UNSOL          4
`define IRQ_SYNC_ERR       5
`define IRQ_W              6

// Control bit positions
`define CTRL_I2C_OWN       0

// AXI responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// File: led_pkg.sv
// Types shared by the network indicator LED driver.
// Assumes led_defines.svh for all numeric constants.
package led_pkg;

   // Slave state as reported by the state machine
   typedef enum logic [2:0] {
      ST_BOOTING      = 3'h0,
      ST_STARTUP      = 3'h1,
      ST_MAILBOX_ONLY = 3'h2,
      ST_INPUTS_ONLY  = 3'h3,
      ST_RUNNING      = 3'h4,
      ST_FW_LOAD      = 3'h5
   } slave_state_type;

   // Light patterns, one-hot
   typedef enum logic [5:0] {
      PAT_OFF     = 6'h01,
      PAT_ON      = 6'h02,
      PAT_BLINK   = 6'h04,
      PAT_SINGLE  = 6'h08,
      PAT_DOUBLE  = 6'h10,
      PAT_FLICKER = 6'h20
   } pattern_type;

   // Error conditions entering the block
   typedef struct packed {
      logic host_wd;     // Host data port watchdog expired
      logic boot_err;    // Booting error
      logic cfg_err;     // General configuration error
      logic app_wd;      // Application watchdog expired
      logic bufch_wd;    // Buffer channel monitor watchdog expired
      logic sync_err;    // Synchronization error
   } err_type;

   // Per-port link inputs
   typedef struct packed {
      logic link_ok;
      logic activity;
   } port_type;

endpackage

// File: led_monitor.sv
// Checker for the indicator LED driver, watching its ports only.
// Assumes it is bound into led_driver; outputs lag inputs 1-2 cycles.
`timescale 1ns/100ps
module led_monitor
(
   // Clock and reset
   input wire logic                     clk,
   input wire logic                     rst,
   // Status inputs
   input wire led_pkg::port_type        port_in,
   input wire led_pkg::slave_state_type slave_state,
   input wire logic                     fw_download,
   input wire logic [7:0]               app_layer_state_reg,
   input wire led_pkg::err_type         err,
   input wire logic                     i2c_sda_oe,
   // Watched outputs
   input wire logic                     port_in_link_indicator,
   input wire logic                     run_led,
   input wire logic                     err_sda_o,
   input wire logic                     err_sda_oe,
   input wire logic                     irq
);
   // Four stable cycles cover the worst output latency
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   chk_link_in_off: assert property
      (!port_in.link_ok [*4] |-> !port_in_link_indicator)
      else $error("port-in LED lit without link");
   chk_link_in_on: assert property
      ((port_in.link_ok && !port_in.activity) [*4] |-> port_in_link_indicator)
      else $error("port-in LED dark on idle link");
   chk_run_on: assert property
      ((slave_state == led_pkg::ST_RUNNING && !fw_download) [*4] |-> run_led)
      else $error("run LED not steady in running state");
   chk_run_startup_off: assert property
      ((slave_state == led_pkg::ST_STARTUP && !fw_download) [*4] |-> !run_led)
      else $error("run LED lit in startup state");
   chk_fw_flicker_start: assert property
      ($rose(fw_download) && slave_state == led_pkg::ST_STARTUP
       |-> ##[1:4] run_led)
      else $error("download flicker did not start lit");
   chk_mbox_blink_start: assert property
      ($changed(slave_state) && slave_state == led_pkg::ST_MAILBOX_ONLY
       && !fw_download |-> ##[1:4] run_led)
      else $error("mailbox blink did not start lit");
   chk_host_wd_on: assert property
      ((err.host_wd && !i2c_sda_oe) [*4] |-> !err_sda_oe || err_sda_o)
      else $error("error LED dark after host watchdog");
   chk_err_idle_off: assert property
      ((err == 6'h00 && app_layer_state_reg != 8'h01 && !i2c_sda_oe) [*4]
       |-> !(err_sda_oe && err_sda_o))
      else $error("error LED lit with no error");

   // Main scenarios reached
   cover property (slave_state == led_pkg::ST_MAILBOX_ONLY && run_led);
   cover property (err.host_wd && err_sda_oe && err_sda_o);
   cover property ($rose(irq));
endmodule // led_monitor

bind led_driver led_monitor led_monitor_i
(
   .clk(clk), .rst(rst), .port_in(port_in), .slave_state(slave_state),
   .fw_download(fw_download), .app_layer_state_reg(app_layer_state_reg),
   .err(err), .i2c_sda_oe(i2c_sda_oe),
   .port_in_link_indicator(port_in_link_indicator), .run_led(run_led),
   .err_sda_o(err_sda_o), .err_sda_oe(err_sda_oe), .irq(irq)
);

// File: led_connector_model.sv
// Connector lamps on the far side of the indicator pins.
// Assumes the shared data pin has a pull-up when nobody drives it.
`timescale 1ns/100ps
module led_connector_model
(
   // Device pins
   input wire logic in_pin,
   input wire logic out_pin,
   input wire logic status_pin,
   input wire logic sda_o,
   input wire logic sda_oe,
   // Lamp and wire states
   output logic     in_lit,
   output logic     out_lit,
   output logic     status_lit,
   output logic     error_lit,
   output logic     sda_wire
);
   // Green lamps follow their drive directly
   assign in_lit     = in_pin;
   assign out_lit    = out_pin;
   assign status_lit = status_pin;
   // Released pin floats high, so only a driven high lights the red lamp
   assign sda_wire   = sda_oe ? sda_o : 1'b1;
   assign error_lit  = sda_oe & sda_o;
endmodule // led_connector_model

// File: tb_top.sv
// Self-checking bench for the indicator LED driver.
// Assumes led_driver, its checker and the lamp model compiled before.
`timescale 1ns/100ps
`include "led_defines.svh"
`define CHK(nm, ex, gt) \
   begin \
      cmp_count++; \
      if ((ex) !== (gt)) \
      begin \
         miscompares++; \
         $display("BAD %s expected %h seen %h", nm, ex, gt); \
      end \
   end
module tb_top;
   logic                     clk, rst, fw_download, i2c_sda_o, i2c_sda_oe;
   led_pkg::port_type        port_in, port_out;
   led_pkg::slave_state_type slave_state;
   logic [7:0]               app_layer_state_reg;
   led_pkg::err_type         err;
   logic                     port_in_link_indicator, port_out_link_indicator;
   logic                     run_led, err_sda_o, err_sda_oe, irq;
   logic [`ADDR_W-1:0]       s_axi_awaddr, s_axi_araddr;
   logic [31:0]              s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]               s_axi_wstrb;
   logic [1:0]               s_axi_bresp, s_axi_rresp, rs;
   logic                     s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic                     s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic                     s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic                     s_axi_rready;
   logic                     in_lit, out_lit, status_lit, error_lit, sda_wire;
   int                       miscompares, cmp_count;

   led_driver led_driver_i
   (
      .clk, .rst, .port_in, .port_out, .slave_state, .fw_download,
      .app_layer_state_reg, .err, .i2c_sda_o, .i2c_sda_oe,
      .port_in_link_indicator, .port_out_link_indicator, .run_led,
      .err_sda_o, .err_sda_oe, .irq, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );
   led_connector_model led_connector_model_i
   (
      .in_pin(port_in_link_indicator), .out_pin(port_out_link_indicator),
      .status_pin(run_led), .sda_o(err_sda_o), .sda_oe(err_sda_oe),
      .in_lit, .out_lit, .status_lit, .error_lit, .sda_wire
   );

   // 250 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic hang(input string s);
      miscompares++;
      $display("BAD %s expected answer seen none", s);
      give_verdict;
   endtask

   // Outputs settle within three cycles; six leaves margin
   task automatic settle;
      repeat (6) @(posedge clk);
   endtask

   // Each channel released at its own handshake edge
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
      int n = 0;
      bit done = 1'b0;
      begin
         @(posedge clk);
         s_axi_awaddr  <= a;
         s_axi_awvalid <= 1'b1;
         s_axi_wdata   <= d;
         s_axi_wvalid  <= 1'b1;
         s_axi_bready  <= 1'b1;
         while (!done && n < 100)
         begin
            @(posedge clk);
            n++;
            if (s_axi_awvalid && s_axi_awready)
               s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
               s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready)
            begin
               done = 1'b1;
               rs = s_axi_bresp;
               s_axi_bready <= 1'b0;
            end
         end
         if (!done)
            hang("write");
      end
   endtask

   task automatic axi_read(input logic [3:0] a);
      int n = 0;
      bit done = 1'b0;
      begin
         @(posedge clk);
         s_axi_araddr  <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready  <= 1'b1;
         while (!done && n < 100)
         begin
            @(posedge clk);
            n++;
            if (s_axi_arvalid && s_axi_arready)
               s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready)
            begin
               done = 1'b1;
               rd = s_axi_rdata;
               rs = s_axi_rresp;
               s_axi_rready <= 1'b0;
            end
         end
         if (!done)
            hang("read");
      end
   endtask

   task automatic t_reset;
      begin
         `CHK("rst_run", 1'b0, run_led)
         `CHK("rst_oe", 1'b0, err_sda_oe)
         `CHK("rst_irq", 1'b0, irq)
         rst <= 1'b0;
         axi_read(`REG_INT_MASK);
         `CHK("mask_rst", 32'h0, rd)
         axi_read(`REG_CONTROL);
         `CHK("ctrl_rst", 32'h0, rd)
         $display("test reset done");
      end
   endtask

   task automatic t_link;
      @(posedge clk);
      port_in  <= 2'b10;
      port_out <= 2'b00;
      settle;
      `CHK("in_idle", 1'b1, in_lit)
      `CHK("out_off", 1'b0, out_lit)
      port_in  <= 2'b00;
      port_out <= 2'b11;
      settle;
      `CHK("in_off", 1'b0, in_lit)
      port_out <= 2'b10;
      settle;
      `CHK("out_idle", 1'b1, out_lit)
      $display("test link done");
   endtask

   task automatic run_case(input led_pkg::slave_state_type s, input logic f,
                           input led_pkg::pattern_type p);
      begin
         slave_state <= s;
         fw_download <= f;
         settle;
         axi_read(`REG_STATUS);
         `CHK("run_pat", p, rd[17:12])
         `CHK("run_lit", p != led_pkg::PAT_OFF, status_lit)
      end
   endtask

   task automatic t_run;
      begin
         run_case(led_pkg::ST_RUNNING, 1'b0, led_pkg::PAT_ON);
         run_case(led_pkg::ST_MAILBOX_ONLY, 1'b0, led_pkg::PAT_BLINK);
         run_case(led_pkg::ST_INPUTS_ONLY, 1'b0, led_pkg::PAT_SINGLE);
         run_case(led_pkg::ST_STARTUP, 1'b0, led_pkg::PAT_OFF);
         run_case(led_pkg::ST_STARTUP, 1'b1, led_pkg::PAT_FLICKER);
         run_case(led_pkg::ST_FW_LOAD, 1'b0, led_pkg::PAT_FLICKER);
         run_case(led_pkg::ST_BOOTING, 1'b0, led_pkg::PAT_FLICKER);
         $display("test run done");
      end
   endtask

   task automatic err_case(input led_pkg::err_type e, input logic [7:0] f,
                           input led_pkg::pattern_type p);
      begin
         err <= e;
         app_layer_state_reg <= f;
         settle;
         axi_read(`REG_STATUS);
         `CHK("err_pat", p, rd[9:4])
         `CHK("err_lit", p != led_pkg::PAT_OFF, error_lit)
      end
   endtask

   // Severity order checked by pairing levels; host watchdog is paired with config error, not boot error
   task automatic t_err;
      slave_state <= led_pkg::ST_MAILBOX_ONLY;
      err_case(6'h20, 8'h00, led_pkg::PAT_ON);
      err_case(6'h08, 8'h00, led_pkg::PAT_BLINK);
      err_case(6'h10, 8'h00, led_pkg::PAT_FLICKER);
      err_case(6'h00, 8'h01, led_pkg::PAT_SINGLE);
      err_case(6'h01, 8'h00, led_pkg::PAT_SINGLE);
      err_case(6'h04, 8'h00, led_pkg::PAT_DOUBLE);
      err_case(6'h02, 8'h00, led_pkg::PAT_DOUBLE);
      err_case(6'h28, 8'h00, led_pkg::PAT_ON);
      err_case(6'h18, 8'h00, led_pkg::PAT_FLICKER);
      err_case(6'h0C, 8'h00, led_pkg::PAT_BLINK);
      err_case(6'h05, 8'h01, led_pkg::PAT_DOUBLE);
      err_case(6'h00, 8'h00, led_pkg::PAT_OFF);
      slave_state <= led_pkg::ST_STARTUP;
      err_case(6'h00, 8'h01, led_pkg::PAT_FLICKER);
      $display("test error done");
   endtask

   task automatic t_share;
      axi_write(`REG_CONTROL, 32'h1);
      err <= 6'h20;
      i2c_sda_o <= 1'b1;
      settle;
      `CHK("sda_free", 1'b1, sda_wire)
      `CHK("i2c_lamp", 1'b0, error_lit)
      i2c_sda_oe <= 1'b1;
      i2c_sda_o  <= 1'b0;
      settle;
      `CHK("sda_i2c", 1'b0, sda_wire)
      axi_write(`REG_CONTROL, 32'h0);
      settle;
      `CHK("sda_led", 1'b1, sda_wire)
      err <= 6'h00;
      i2c_sda_oe <= 1'b0;
      $display("test share done");
   endtask

   // Sticky bits, mask, one-to-clear, refused accesses
   task automatic t_irq;
      axi_write(`REG_INT_STATUS, 32'h3F);
      axi_write(`REG_INT_MASK, 32'h4);
      err <= 6'h09;
      settle;
      `CHK("irq_on", 1'b1, irq)
      axi_read(`REG_INT_STATUS);
      `CHK("int_st", 32'h24, rd)
      err <= 6'h00;
      axi_write(`REG_INT_STATUS, 32'h4);
      settle;
      `CHK("irq_clr", 1'b0, irq)
      axi_write(`REG_INT_MASK, 32'h20);
      settle;
      `CHK("irq_mask", 1'b1, irq)
      s_axi_wstrb <= 4'h0;
      axi_write(`REG_INT_MASK, 32'h0);
      settle;
      `CHK("strb_off", 1'b1, irq)
      s_axi_wstrb <= 4'hF;
      axi_write(`REG_INT_STATUS, 32'h20);
      settle;
      `CHK("irq_off", 1'b0, irq)
      axi_read(4'h2);
      `CHK("bad_rd", `RESP_SLVERR, rs)
      axi_write(`REG_STATUS, 32'h0);
      `CHK("ro_wr", `RESP_SLVERR, rs)
      $display("test irq done");
   endtask

   // Stimulus sequence
   initial
   begin
      {rst, fw_download, i2c_sda_o, i2c_sda_oe} = 4'h8;
      {port_in, port_out, err, app_layer_state_reg} = 18'h0;
      slave_state = led_pkg::ST_BOOTING;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
      s_axi_wstrb = 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      miscompares = 0;
      cmp_count = 0;
      repeat (5) @(posedge clk);
      t_reset;
      t_link;
      t_run;
      t_err;
      t_share;
      t_irq;
      give_verdict;
   end
endmodule // tb_top
